/* File: core/pmir_defs.vh */
// Constants for the power mode and interrupt routing block
`ifndef PMIR_DEFS_VH
`define PMIR_DEFS_VH

// ****************************************************
// Register offsets
// ****************************************************
`define PMIR_ADDR_SYS_MODE        8'h0b
`define PMIR_ADDR_IRQ_SOURCE      8'h0c
`define PMIR_ADDR_POWER_MODE      8'h2b
`define PMIR_ADDR_WAKE_PIN_CFG    8'h2c
`define PMIR_ADDR_IRQ_ENABLE      8'h2d
`define PMIR_ADDR_IRQ_ROUTE       8'h2e

// ****************************************************
// Field positions in power_mode_control
// ****************************************************
`define PMIR_PM_SELF_TEST         7
`define PMIR_PM_SOFT_RESET        6
`define PMIR_PM_SLEEP_OS_HI       4
`define PMIR_PM_SLEEP_OS_LO       3
`define PMIR_PM_AUTO_SLEEP        2
`define PMIR_PM_WAKE_OS_HI        1
`define PMIR_PM_WAKE_OS_LO        0

// ****************************************************
// Field positions in wake_source_and_pin_config
// ****************************************************
`define PMIR_WK_TRANSIENT         6
`define PMIR_WK_ORIENTATION       5
`define PMIR_WK_PULSE             4
`define PMIR_WK_FREEFALL_MOTION   3
`define PMIR_CFG_IRQ_POLARITY     1
`define PMIR_CFG_IRQ_DRIVE        0

// ****************************************************
// Source bit positions (enable, route and source flags)
// ****************************************************
`define PMIR_SRC_AUTOSLEEP        7
`define PMIR_SRC_TRANSIENT        5
`define PMIR_SRC_ORIENTATION      4
`define PMIR_SRC_PULSE            3
`define PMIR_SRC_FREEFALL_MOTION  2
`define PMIR_SRC_DATA_READY       0

// ****************************************************
// Writable bits and reset values
// ****************************************************
`define PMIR_MASK_POWER_MODE      8'hdf
`define PMIR_MASK_WAKE_PIN_CFG    8'h7b
`define PMIR_MASK_SOURCES         8'hbd
`define PMIR_RST_POWER_MODE       8'h00
`define PMIR_RST_WAKE_PIN_CFG     8'h00
`define PMIR_RST_IRQ_ENABLE       8'h00
`define PMIR_RST_IRQ_ROUTE        8'h00

// ****************************************************
// Oversampling schemes and system modes
// ****************************************************
`define PMIR_OS_NORMAL            2'h0
`define PMIR_OS_LOW_NOISE_LP      2'h1
`define PMIR_OS_HIGH_RES          2'h2
`define PMIR_OS_LOW_POWER         2'h3
`define PMIR_MODE_STANDBY         2'h0
`define PMIR_MODE_WAKE            2'h1
`define PMIR_MODE_SLEEP           2'h2

// ****************************************************
// Timing
// ****************************************************
`define PMIR_BOOT_CYCLES          20

`endif

/* File: core/pmir_irq_pin.v */
// One interrupt pin driver with polarity and drive type selection
`timescale 1ns/10ps

module pmir_irq_pin (
   input  wire clk_i,        // System clock
   input  wire rst_n_i,      // Synchronous reset, active low
   input  wire ce_i,         // Clock enable
   input  wire assert_i,     // Any routed source active
   input  wire polarity_i,   // 1: asserted level is high
   input  wire open_drain_i, // 1: open-drain drive
   output reg  pin_o,        // Pin output value
   output reg  pin_oe_o      // Pin output enable
);

   // ****************************************************
   // Registered pin drive
   // ****************************************************
   // Push-pull drives always; open drain drives only the asserted level
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         pin_o    <= 1'b1;
         pin_oe_o <= 1'b1;
      end else if (ce_i) begin
         if (open_drain_i) begin
            pin_o    <= polarity_i;
            pin_oe_o <= assert_i;
         end else begin
            pin_o    <= assert_i ? polarity_i : ~polarity_i;
            pin_oe_o <= 1'b1;
         end
      end
   end

endmodule // pmir_irq_pin

/* File: core/pmir_sleep_ctl.v */
// Wake and sleep state tracking for auto-sleep
`timescale 1ns/10ps
`include "pmir_defs.vh"

module pmir_sleep_ctl (
   input  wire       clk_i,           // System clock
   input  wire       rst_n_i,         // Synchronous reset incl. soft reset, active low
   input  wire       ce_i,            // Clock enable
   input  wire       active_i,        // Device in active mode
   input  wire       auto_sleep_en_i, // Auto-sleep enable
   input  wire       sleep_timeout_i, // Inactivity period elapsed
   input  wire       wake_req_i,      // Wake-qualifying event present
   output wire [1:0] sys_mode_o,      // Standby, wake or sleep
   output reg        transition_o     // Pulse on wake/sleep change
);

   reg sleeping_r;   // Current sleep state
   reg sleeping_nxt; // Next sleep state

   // ****************************************************
   // Next state
   // ****************************************************
   always @* begin
      sleeping_nxt = sleeping_r;
      if (!active_i || !auto_sleep_en_i) begin
         sleeping_nxt = 1'b0;
      end else if (!sleeping_r && sleep_timeout_i) begin
         sleeping_nxt = 1'b1;
      end else if (sleeping_r && wake_req_i) begin
         sleeping_nxt = 1'b0;
      end
   end

   // ****************************************************
   // State register and transition pulse
   // ****************************************************
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         sleeping_r   <= 1'b0;
         transition_o <= 1'b0;
      end else if (ce_i) begin
         sleeping_r   <= sleeping_nxt;
         transition_o <= auto_sleep_en_i & (sleeping_nxt ^ sleeping_r);
      end
   end

   // System mode seen by the host
   assign sys_mode_o = !active_i ? `PMIR_MODE_STANDBY :
                       (sleeping_r ? `PMIR_MODE_SLEEP : `PMIR_MODE_WAKE);

endmodule // pmir_sleep_ctl

/* File: core/pmir_top.v */
// Power mode control and interrupt routing top level
`timescale 1ns/10ps
`include "pmir_defs.vh"

// Overview of operation
// - Self-test bit shifts all three axis outputs
// - Writing soft reset bit resets device immediately
// - Soft reset restores every register default
// - Soft reset also resets serial host logic
// - Reset bit is never stored, always reads zero
// - Scheme codes: normal, LNLP, high-res, low-power
// - Separate wake and sleep schemes, state selects
// - Averaging ratio from scheme and output rate
// - Auto-sleep transitions only when enable set
// - Wake bits let function interrupts wake device
// - Polarity bit sets asserted level, both pins
// - Drive bit selects push-pull or open drain
// - Per-source enable gates flags to controller
// - Route bit: 1 first pin, 0 second
// - Pin asserted while any routed source active
// - Enter sleep after inactivity, switch rate
module pmir_top #(
   parameter BOOT_CYCLES = `PMIR_BOOT_CYCLES // Boot length after soft reset
) (
   input  wire       clk_i,             // System clock, 20 MHz
   input  wire       rst_n_i,           // Synchronous reset, active low
   input  wire       ce_i,              // Clock enable
   input  wire [7:0] reg_addr_i,        // Register address from serial logic
   input  wire       reg_wr_i,          // Register write strobe
   input  wire [7:0] reg_wdata_i,       // Register write data
   input  wire       reg_rd_i,          // Register read strobe
   output reg  [7:0] reg_rdata_o,       // Register read data
   output reg        serial_rst_o,      // Reset to serial host logic
   output wire       boot_busy_o,       // Boot sequence running
   input  wire       active_i,          // Device active (not standby)
   input  wire [2:0] rate_sel_i,        // Wake output rate code
   input  wire [2:0] sleep_rate_sel_i,  // Sleep output rate code
   input  wire [7:0] src_flags_i,       // Event flags of the functional engines
   input  wire       sleep_timeout_i,   // Inactivity period elapsed
   output reg        activity_o,        // Restarts the inactivity timer
   output reg        self_test_o,       // Self-test stimulus on
   output reg  [1:0] os_scheme_o,       // Oversampling scheme in use
   output reg  [2:0] eff_rate_o,        // Output rate code in use
   output reg  [3:0] avg_log2_o,        // Log2 of samples averaged per output
   output wire [1:0] sys_mode_o,        // Standby, wake or sleep
   output wire       irq_pin_first_o,   // First interrupt pin value
   output wire       irq_pin_first_oe_o,  // First interrupt pin enable
   output wire       irq_pin_second_o,  // Second interrupt pin value
   output wire       irq_pin_second_oe_o  // Second interrupt pin enable
);

   // ****************************************************
   // Declarations
   // ****************************************************
   reg  [7:0]  power_mode_control_r;         // Self-test, schemes, auto-sleep
   reg  [7:0]  wake_source_and_pin_config_r; // Wake sources and pin config
   reg  [7:0]  interrupt_enable_mask_r;      // Per-source enables
   reg  [7:0]  interrupt_pin_route_r;        // Per-source routing
   reg         aslp_flag_r;                  // Sticky auto-sleep change flag
   reg  [15:0] boot_cnt_r;                   // Boot cycles remaining
   reg         soft_rst_r;                   // Internal reset pulse
   wire        wr_soft_rst;                  // Write of 1 to the reset bit
   wire        core_rst_n;                   // Combined reset, active low
   wire        aslp_event;                   // Wake/sleep change pulse
   wire [7:0]  src_all;                      // All source flags
   wire [7:0]  src_enabled;                  // Enabled source flags
   wire        wake_req;                     // Wake-qualifying event
   wire        sleeping;                     // Sleep state active
   wire        assert_first;                 // Any source routed to pin one
   wire        assert_second;                // Any source routed to pin two

   // ****************************************************
   // Reset and soft reset
   // ****************************************************
   assign wr_soft_rst = reg_wr_i && (reg_addr_i == `PMIR_ADDR_POWER_MODE) &&
                        reg_wdata_i[`PMIR_PM_SOFT_RESET];
   assign core_rst_n  = rst_n_i & ~soft_rst_r;
   assign boot_busy_o = (boot_cnt_r != 16'h0000);

   // Soft reset pulse and boot counter
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         soft_rst_r   <= 1'b0;
         boot_cnt_r   <= 16'h0000;
         serial_rst_o <= 1'b0;
      end else if (ce_i) begin
         soft_rst_r <= wr_soft_rst;
         if (wr_soft_rst) begin
            boot_cnt_r <= BOOT_CYCLES[15:0];
         end else if (boot_cnt_r != 16'h0000) begin
            boot_cnt_r <= boot_cnt_r - 16'h0001;
         end
         // Serial logic held in reset from the write until boot ends
         serial_rst_o <= wr_soft_rst | (boot_cnt_r > 16'h0001);
      end
   end

   // ****************************************************
   // Register file
   // ****************************************************
   // Writes of the host; soft reset returns every field to default
   always @(posedge clk_i) begin
      if (!core_rst_n) begin
         power_mode_control_r         <= `PMIR_RST_POWER_MODE;
         wake_source_and_pin_config_r <= `PMIR_RST_WAKE_PIN_CFG;
         interrupt_enable_mask_r      <= `PMIR_RST_IRQ_ENABLE;
         interrupt_pin_route_r        <= `PMIR_RST_IRQ_ROUTE;
      end else if (ce_i && reg_wr_i && !wr_soft_rst) begin
         case (reg_addr_i)
            `PMIR_ADDR_POWER_MODE: begin
               // Reset bit is never stored, so it reads as zero
               power_mode_control_r <= reg_wdata_i & `PMIR_MASK_POWER_MODE
                                       & ~(8'h01 << `PMIR_PM_SOFT_RESET);
            end
            `PMIR_ADDR_WAKE_PIN_CFG: begin
               wake_source_and_pin_config_r <= reg_wdata_i & `PMIR_MASK_WAKE_PIN_CFG;
            end
            `PMIR_ADDR_IRQ_ENABLE: begin
               interrupt_enable_mask_r <= reg_wdata_i & `PMIR_MASK_SOURCES;
            end
            `PMIR_ADDR_IRQ_ROUTE: begin
               interrupt_pin_route_r <= reg_wdata_i & `PMIR_MASK_SOURCES;
            end
            default: begin
            end
         endcase
      end
   end

   // Read data, registered; unmapped addresses read zero
   always @(posedge clk_i) begin
      if (!core_rst_n) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         case (reg_addr_i)
            `PMIR_ADDR_SYS_MODE:     reg_rdata_o <= {6'h00, sys_mode_o};
            `PMIR_ADDR_IRQ_SOURCE:   reg_rdata_o <= src_all;
            `PMIR_ADDR_POWER_MODE:   reg_rdata_o <= power_mode_control_r;
            `PMIR_ADDR_WAKE_PIN_CFG: reg_rdata_o <= wake_source_and_pin_config_r;
            `PMIR_ADDR_IRQ_ENABLE:   reg_rdata_o <= interrupt_enable_mask_r;
            `PMIR_ADDR_IRQ_ROUTE:    reg_rdata_o <= interrupt_pin_route_r;
            default:                 reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ****************************************************
   // Auto-sleep flag
   // ****************************************************
   // Set on each wake/sleep change with auto-sleep enabled, cleared by reading system mode; set wins
   always @(posedge clk_i) begin
      if (!core_rst_n) begin
         aslp_flag_r <= 1'b0;
      end else if (ce_i) begin
         if (aslp_event) begin
            aslp_flag_r <= 1'b1;
         end else if (reg_rd_i && reg_addr_i == `PMIR_ADDR_SYS_MODE) begin
            aslp_flag_r <= 1'b0;
         end
      end
   end

   // ****************************************************
   // Source gating and wake qualification
   // ****************************************************
   assign src_all     = (src_flags_i & `PMIR_MASK_SOURCES & ~(8'h01 << `PMIR_SRC_AUTOSLEEP))
                        | ({7'h00, aslp_flag_r} << `PMIR_SRC_AUTOSLEEP);
   assign src_enabled = src_all & interrupt_enable_mask_r;
   // Wake bits sit one place above the matching source bits
   assign wake_req    = |(src_enabled[`PMIR_SRC_TRANSIENT:`PMIR_SRC_FREEFALL_MOTION] &
                          wake_source_and_pin_config_r[`PMIR_WK_TRANSIENT:`PMIR_WK_FREEFALL_MOTION]);
   assign sleeping    = (sys_mode_o == `PMIR_MODE_SLEEP);

   // Activity from enabled motion functions restarts the inactivity timer
   always @(posedge clk_i) begin
      if (!core_rst_n) begin
         activity_o <= 1'b0;
      end else if (ce_i) begin
         activity_o <= |src_enabled[`PMIR_SRC_TRANSIENT:`PMIR_SRC_FREEFALL_MOTION];
      end
   end

   // ****************************************************
   // Wake/sleep state
   // ****************************************************
   pmir_sleep_ctl u_sleep (
      .clk_i           (clk_i),
      .rst_n_i         (core_rst_n),
      .ce_i            (ce_i),
      .active_i        (active_i),
      .auto_sleep_en_i (power_mode_control_r[`PMIR_PM_AUTO_SLEEP]),
      .sleep_timeout_i (sleep_timeout_i),
      .wake_req_i      (wake_req),
      .sys_mode_o      (sys_mode_o),
      .transition_o    (aslp_event)
   );

   // ****************************************************
   // Oversampling and averaging ratio
   // ****************************************************
   // Log2 of the averaging ratio per scheme and rate code (0 is fastest)
   function [3:0] avg_log2;
      input [1:0] scheme;
      input [2:0] rate;
      reg   [31:0] row;
      begin
         case (scheme)
            `PMIR_OS_NORMAL:       row = 32'h75422221;
            `PMIR_OS_LOW_NOISE_LP: row = 32'h53222221;
            `PMIR_OS_HIGH_RES:     row = 32'ha8754321;
            `PMIR_OS_LOW_POWER:    row = 32'h42111111;
            default:               row = 32'h75422221;
         endcase
         avg_log2 = row[{rate, 2'b00} +: 4];
      end
   endfunction

   // Scheme and rate follow the current wake or sleep state
   always @(posedge clk_i) begin
      if (!core_rst_n) begin
         self_test_o <= 1'b0;
         os_scheme_o <= `PMIR_OS_NORMAL;
         eff_rate_o  <= 3'h0;
         avg_log2_o  <= 4'h1;
      end else if (ce_i) begin
         self_test_o <= power_mode_control_r[`PMIR_PM_SELF_TEST];
         if (sleeping) begin
            os_scheme_o <= power_mode_control_r[`PMIR_PM_SLEEP_OS_HI:`PMIR_PM_SLEEP_OS_LO];
            eff_rate_o  <= sleep_rate_sel_i;
            avg_log2_o  <= avg_log2(power_mode_control_r[`PMIR_PM_SLEEP_OS_HI:`PMIR_PM_SLEEP_OS_LO],
                                    sleep_rate_sel_i);
         end else begin
            os_scheme_o <= power_mode_control_r[`PMIR_PM_WAKE_OS_HI:`PMIR_PM_WAKE_OS_LO];
            eff_rate_o  <= rate_sel_i;
            avg_log2_o  <= avg_log2(power_mode_control_r[`PMIR_PM_WAKE_OS_HI:`PMIR_PM_WAKE_OS_LO],
                                    rate_sel_i);
         end
      end
   end

   // ****************************************************
   // Interrupt routing and pins
   // ****************************************************
   assign assert_first  = |(src_enabled & interrupt_pin_route_r);
   assign assert_second = |(src_enabled & ~interrupt_pin_route_r);

   pmir_irq_pin u_pin_first (
      .clk_i        (clk_i),
      .rst_n_i      (core_rst_n),
      .ce_i         (ce_i),
      .assert_i     (assert_first),
      .polarity_i   (wake_source_and_pin_config_r[`PMIR_CFG_IRQ_POLARITY]),
      .open_drain_i (wake_source_and_pin_config_r[`PMIR_CFG_IRQ_DRIVE]),
      .pin_o        (irq_pin_first_o),
      .pin_oe_o     (irq_pin_first_oe_o)
   );

   pmir_irq_pin u_pin_second (
      .clk_i        (clk_i),
      .rst_n_i      (core_rst_n),
      .ce_i         (ce_i),
      .assert_i     (assert_second),
      .polarity_i   (wake_source_and_pin_config_r[`PMIR_CFG_IRQ_POLARITY]),
      .open_drain_i (wake_source_and_pin_config_r[`PMIR_CFG_IRQ_DRIVE]),
      .pin_o        (irq_pin_second_o),
      .pin_oe_o     (irq_pin_second_oe_o)
   );

endmodule // pmir_top

/* File: sim/pmir_host.sv */
// Host model on the register port and the interrupt lines
`timescale 1ns/10ps
module pmir_host (
   input  wire       clk_i,       // System clock
   input  wire [7:0] reg_rdata_i, // Read data
   input  wire       first_i,     // First pin value
   input  wire       first_oe_i,  // First pin enable
   input  wire       second_i,    // Second pin value
   input  wire       second_oe_i, // Second pin enable
   output reg  [7:0] reg_addr_o  = 8'h00,
   output reg        reg_wr_o    = 1'b0,
   output reg  [7:0] reg_wdata_o = 8'h00,
   output reg        reg_rd_o    = 1'b0,
   output wire       line_first_o,  // Resolved first line
   output wire       line_second_o  // Resolved second line
);
   // Pull-ups hold released lines high
   assign line_first_o = first_oe_i ? first_i : 1'b1;
   assign line_second_o = second_oe_i ? second_i : 1'b1;
   // One-cycle write strobe
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      #1;
   endtask
   // One-cycle read strobe, data taken a cycle later
   task rd(input [7:0] a, output [7:0] q);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      #1 q = reg_rdata_i;
   endtask
   // Learns the raising sources after a pin assert
   task service(output [7:0] q);
      rd(8'h0c, q);
   endtask
endmodule // pmir_host

/* File: sim/pmir_top_chk.sv */
// Concurrent checks on the pmir_top ports
`timescale 1ns/10ps
module pmir_chk #(
   parameter BOOT_CYCLES = 2 // Boot length of the bound block
) (
   input wire       clk_i,
   input wire       rst_n_i,
   input wire       ce_i,
   input wire [7:0] reg_addr_i,
   input wire       reg_wr_i,
   input wire [7:0] reg_wdata_i,
   input wire       reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire       serial_rst_o,
   input wire [7:0] src_flags_i,
   input wire       sleep_timeout_i,
   input wire       self_test_o,
   input wire [1:0] os_scheme_o,
   input wire [1:0] sys_mode_o,
   input wire       irq_pin_first_o,
   input wire       irq_pin_first_oe_o
);
   reg  [7:0] pm_r;                 // Shadow power mode bits
   reg  [7:0] cfg_r;                // Shadow pin configuration
   reg  [7:0] sr_r;                 // Cycles of serial reset so far
   wire       wr_w = ce_i & reg_wr_i; // Write taken this edge
   // ************************************
   // Shadows, soft reset writes not stored
   // ************************************
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         pm_r <= 8'h00;
         cfg_r <= 8'h00;
         sr_r <= 8'h00;
      end else begin
         if (wr_w && reg_addr_i == 8'h2b && !reg_wdata_i[6]) pm_r <= reg_wdata_i & 8'h9f;
         if (wr_w && reg_addr_i == 8'h2c) cfg_r <= reg_wdata_i & 8'h7b;
         sr_r <= serial_rst_o ? sr_r + 8'h01 : 8'h00;
         // Soft reset returns the shadows to defaults with the block
         if (serial_rst_o && sr_r == 8'h00) begin
            pm_r <= 8'h00;
            cfg_r <= 8'h00;
         end
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_soft_wr; wr_w && reg_addr_i == 8'h2b && reg_wdata_i[6]; endsequence
   property p_rd_zero; ce_i && reg_rd_i && reg_addr_i == 8'h2b |=> !reg_rdata_o[6]; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("reset bit read as one");
   property p_soft; s_soft_wr |=> serial_rst_o; endproperty
   a_soft: assert property (p_soft) else $error("no serial reset after soft reset");
   property p_boot; $fell(serial_rst_o) |-> sr_r == BOOT_CYCLES; endproperty
   a_boot: assert property (p_boot) else $error("serial reset length wrong");
   property p_st; wr_w && reg_addr_i == 8'h2b && !reg_wdata_i[6] |-> ##2 self_test_o == $past(reg_wdata_i[7], 2); endproperty
   a_st: assert property (p_st) else $error("self test output wrong");
   property p_pp; $stable(cfg_r) && !cfg_r[0] |-> irq_pin_first_oe_o; endproperty
   a_pp: assert property (p_pp) else $error("push-pull pin not driven");
   property p_od; $stable(cfg_r) && cfg_r[0] && irq_pin_first_oe_o |-> irq_pin_first_o == cfg_r[1]; endproperty
   a_od: assert property (p_od) else $error("open drain drove idle level");
   property p_quiet; $stable(cfg_r) && $past(src_flags_i) == 8'h00 |-> !irq_pin_first_oe_o || irq_pin_first_o != cfg_r[1]; endproperty
   a_quiet: assert property (p_quiet) else $error("pin asserted with no source");
   property p_slp; $rose(sys_mode_o == 2'h2) |-> $past(pm_r[2] && sleep_timeout_i); endproperty
   a_slp: assert property (p_slp) else $error("sleep without enable and timeout");
   property p_os; $stable(pm_r) && $stable(sys_mode_o) |-> os_scheme_o == (sys_mode_o == 2'h2 ? pm_r[4:3] : pm_r[1:0]); endproperty
   a_os: assert property (p_os) else $error("scheme in use wrong");
endmodule // pmir_chk
bind pmir_top pmir_chk #(.BOOT_CYCLES(BOOT_CYCLES)) u_chk (.*);

/* File: sim/pmir_top_test.sv */
// Self-checking bench for the power mode and interrupt routing block
`timescale 1ns/10ps
module pmir_top_test;
   reg        clk_i = 1'b0;
   reg        rst_n_i = 1'b0;
   reg        active_i = 1'b0;
   reg  [2:0] rate_sel_i = 3'h0;
   reg  [2:0] sleep_rate_sel_i = 3'h7;
   reg  [7:0] src_flags_i = 8'h00;
   reg        sleep_timeout_i = 1'b0;
   reg  [7:0] q;
   wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   wire       reg_wr_i, reg_rd_i, serial_rst_o, boot_busy_o, activity_o, self_test_o;
   wire [1:0] os_scheme_o, sys_mode_o;
   wire [2:0] eff_rate_o;
   wire [3:0] avg_log2_o;
   wire       p1, p1_oe, p2, p2_oe, line1, line2;
   integer    failures = 0;
   integer    checked = 0;
   always #25 clk_i = ~clk_i;
   pmir_top #(.BOOT_CYCLES(2)) dut (.*, .ce_i(1'b1), .irq_pin_first_o(p1), .irq_pin_first_oe_o(p1_oe),
      .irq_pin_second_o(p2), .irq_pin_second_oe_o(p2_oe));
   pmir_host host (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o), .first_i(p1), .first_oe_i(p1_oe),
      .second_i(p2), .second_oe_i(p2_oe), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .line_first_o(line1), .line_second_o(line2));
   // Compare and count
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked = checked + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task complete_run;
      if (failures == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Expected line level from assert state, polarity and drive
   function lvl(input on, input [1:0] cfg);
      lvl = on ? cfg[1] : (cfg[0] | ~cfg[1]);
   endfunction
   // Defaults, unmapped read, idle first pin
   task t_defaults;
      integer i;
      for (i = 0; i < 5; i = i + 1) begin
         host.rd((i == 4) ? 8'h30 : 8'h2b + i, q);
         chk("default", 8'h00, q);
      end
      chk("idle first", 8'h01, {7'h00, line1});
   endtask
   // Reserved bits and scheme codes
   task t_masks;
      integer i;
      for (i = 0; i < 4; i = i + 1) host.wr(8'h2b + i, (i == 0) ? 8'hbb : 8'hff);
      for (i = 0; i < 4; i = i + 1) begin
         host.rd(8'h2b + i, q);
         chk("mask", (i == 0) ? 8'h9b : (i == 1) ? 8'h7b : 8'hbd, q);
      end
      for (i = 0; i < 4; i = i + 1) begin
         host.wr(8'h2b, i);
         cyc(2);
         chk("scheme", i, {6'h00, os_scheme_o});
      end
      for (i = 0; i < 4; i = i + 1) host.wr(8'h2b + i, 8'h00);
   endtask
   // Enable, route, polarity and drive over every source except auto-sleep
   task t_pins;
      integer c, s;
      reg [7:0] b;
      for (c = 0; c < 4; c = c + 1) begin
         host.wr(8'h2c, c);
         for (s = 0; s < 6; s = s + 1) begin
            b = 8'h01 << s;
            if (b & 8'h3d) begin
               host.wr(8'h2d, b);
               host.wr(8'h2e, s[0] ? b : 8'h00);
               @(posedge clk_i) src_flags_i <= 8'h3d;
               cyc(3);
               chk("first", {7'h00, lvl(s[0], c[1:0])}, {7'h00, line1});
               chk("second", {7'h00, lvl(!s[0], c[1:0])}, {7'h00, line2});
               host.service(q);
               chk("source", 8'h3d, q);
               @(posedge clk_i) src_flags_i <= 8'h00;
               cyc(3);
               chk("released", {7'h00, lvl(1'b0, c[1:0])}, {7'h00, line1});
            end
         end
      end
      host.wr(8'h2c, 8'h00);
      host.wr(8'h2d, 8'h00);
   endtask
   // Wake, sleep and wake-up sources
   task t_sleep;
      @(posedge clk_i) active_i <= 1'b1;
      host.wr(8'h2b, 8'h15);
      cyc(3);
      chk("wake mode", 8'h01, {6'h00, sys_mode_o});
      chk("wake scheme", 8'h01, {6'h00, os_scheme_o});
      chk("wake avg", 8'h01, {4'h0, avg_log2_o});
      @(posedge clk_i) sleep_timeout_i <= 1'b1;
      @(posedge clk_i) sleep_timeout_i <= 1'b0;
      cyc(3);
      chk("sleep mode", 8'h02, {6'h00, sys_mode_o});
      chk("sleep rate", 8'h07, {5'h00, eff_rate_o});
      chk("sleep scheme", 8'h02, {6'h00, os_scheme_o});
      chk("sleep avg", 8'h0a, {4'h0, avg_log2_o});
      host.service(q);
      chk("sleep flag", 8'h80, q);
      host.wr(8'h2d, 8'h04);
      @(posedge clk_i) src_flags_i <= 8'h04;
      cyc(3);
      chk("no wake bit", 8'h02, {6'h00, sys_mode_o});
      chk("activity", 8'h01, {7'h00, activity_o});
      host.wr(8'h2c, 8'h08);
      cyc(3);
      chk("woken", 8'h01, {6'h00, sys_mode_o});
      @(posedge clk_i) src_flags_i <= 8'h00;
      host.wr(8'h2b, 8'h11);
      @(posedge clk_i) sleep_timeout_i <= 1'b1;
      @(posedge clk_i) sleep_timeout_i <= 1'b0;
      cyc(3);
      host.rd(8'h0b, q);
      chk("no auto sleep", 8'h01, q);
      host.wr(8'h2c, 8'h00);
      host.wr(8'h2d, 8'h00);
      host.wr(8'h2b, 8'h00);
      @(posedge clk_i) active_i <= 1'b0;
   endtask
   // Self test, then soft reset back to defaults
   task t_reset;
      integer i;
      host.wr(8'h2b, 8'h80);
      cyc(2);
      chk("self test", 8'h01, {7'h00, self_test_o});
      host.wr(8'h2d, 8'hbd);
      host.wr(8'h2e, 8'hbd);
      host.wr(8'h2b, 8'hc0);
      chk("serial reset", 8'h01, {7'h00, serial_rst_o});
      i = 0;
      while ((boot_busy_o !== 1'b0 || serial_rst_o !== 1'b0) && i < 50) begin
         cyc(1);
         i = i + 1;
      end
      if (i == 50) begin
         failures = failures + 1;
         complete_run;
      end
      for (i = 0; i < 4; i = i + 1) begin
         host.rd(8'h2b + i, q);
         chk("after reset", 8'h00, q);
      end
      chk("self test off", 8'h00, {7'h00, self_test_o});
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_defaults;
      t_masks;
      t_pins;
      t_sleep;
      t_reset;
      complete_run;
   end
endmodule // pmir_top_test
